// File: hdl/spb_pkg.sv
/*
 * spb_pkg: constants and types of the serial port register bank.
 * assumes a plain register port with word-aligned byte addresses.
 */
package spb_pkg;
    // register bases and aliases (byte addresses)
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_CTRL_EXTRA = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h20;
    localparam logic [7:0] ADDR_DATA       = 8'h30;
    localparam logic [7:0] ADDR_BAUD       = 8'h40;
    localparam logic [7:0] ALIAS_CLR       = 8'h04;
    localparam logic [7:0] ALIAS_SET       = 8'h08;
    localparam logic [7:0] ALIAS_INV       = 8'h0c;
    localparam logic [7:0] ALIAS_MASK      = 8'h0c;
    // implemented bit masks
    localparam logic [31:0] CTRL_MASK       = 32'hff83_bfff;
    localparam logic [31:0] CTRL_EXTRA_MASK = 32'h0000_9f8b;
    localparam logic [31:0] STATUS_WR_MASK  = 32'h0000_0040;
    localparam logic [31:0] BAUD_MASK       = 32'h0000_1fff;
    // control, extra and status fields
    localparam int CTRL_ON_BIT       = 15;
    localparam int CTRL_OUT_DIS_BIT  = 12;
    localparam int CTRL_WSEL_HI_BIT  = 11;
    localparam int CTRL_WSEL_LO_BIT  = 10;
    localparam int CTRL_ROLE_BIT     = 5;
    localparam int CTRL_IN_DIS_BIT   = 4;
    localparam int EXTRA_AUDIO_BIT   = 7;
    localparam int STATUS_OVF_BIT    = 6;
    localparam int STATUS_BUSY_BIT   = 11;
    // reset values
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    localparam logic [31:0] CTRL_EXTRA_RESET = 32'h0000_0000;
    localparam logic [31:0] BAUD_RESET       = 32'h0000_0000;
    localparam logic [31:0] DATA_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        SPB_W8  = 2'b00,
        SPB_W16 = 2'b01,
        SPB_W32 = 2'b10,
        SPB_WAUD = 2'b11
    } spb_width_t;

    typedef enum logic [1:0] {
        SPB_OP_WRITE = 2'b00,
        SPB_OP_CLR   = 2'b01,
        SPB_OP_SET   = 2'b10,
        SPB_OP_INV   = 2'b11
    } spb_op_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } spb_req_t;
endpackage

// File: hdl/spb_bank.sv
/*
 * spb_bank: register bank of the serial port with clear/set/invert aliases.
 * assumes a single-cycle strobe bus on MCLK; shift engine lives elsewhere and
 * feeds busy, a receive-valid strobe and received data through plain inputs.
 */
// Overview of operation
// - clear alias at base plus 0x4 clears bits written as one
// - set alias at base plus 0x8 sets bits written as one
// - invert alias at base plus 0xC toggles bits written as one
// - unimplemented bits read zero and ignore writes
// - baud divisor field is 13 low bits, rest unimplemented
// - while port enabled only the on bit and pin disable bits of control may change; extra and baud stay writable
// - without audio, width bits select 32, 16 or 8 bit words
`timescale 1ns/1ps
`default_nettype none
module spb_bank #(
    parameter int BAUD_WIDTH = 13
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        NRST,
    // register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // shift engine side
    input  wire logic        ENGINE_BUSY,
    input  wire logic        ENGINE_RX_VALID,
    input  wire logic [31:0] ENGINE_RX_DATA,
    output logic             PORT_ENABLE,
    output logic             CONTROLLER_ROLE_SELECT,
    output logic             OUTPUT_PIN_DISABLE,
    output logic             INPUT_PIN_DISABLE,
    output logic [1:0]       WORD_WIDTH,
    output logic [31:0]      TX_DATA,
    output logic             TX_LOAD,
    output logic [12:0]      BAUD_DIVISOR_FIELD
);
    spb_pkg::spb_req_t req;
    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [31:0] port_control;
    logic [31:0] port_control_extra;
    logic [31:0] port_status_sw;
    logic [31:0] data_buffer;
    logic [31:0] baud_divisor;
    logic        overflow;
    logic [31:0] next_control;
    logic [31:0] next_extra;
    logic [31:0] next_baud;
    logic [31:0] next_ovf_word;
    logic [31:0] ctrl_wmask;
    logic [31:0] status_word;
    logic [31:0] baud_impl;

    // base address decode, used for writes to control, extra, status and baud registers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = ((a & ~spb_pkg::ALIAS_MASK) == base);
    endfunction

    function automatic spb_pkg::spb_op_t op_of(input logic [7:0] a);
        op_of = spb_pkg::spb_op_t'(a[3:2]);
    endfunction

    // alias update, masked to implemented bits
    function automatic logic [31:0] apply(input logic [31:0] cur,
                                          input logic [31:0] wd,
                                          input spb_pkg::spb_op_t op,
                                          input logic [31:0] mask);
        logic [31:0] r;
        case (op)
            spb_pkg::SPB_OP_WRITE: r = wd;
            spb_pkg::SPB_OP_CLR:   r = cur & ~wd;
            spb_pkg::SPB_OP_SET:   r = cur | wd;
            spb_pkg::SPB_OP_INV:   r = cur ^ wd;
            default:               r = cur;
        endcase
        apply = (r & mask) | (cur & ~mask);
    endfunction

    assign baud_impl = spb_pkg::BAUD_MASK & ((32'h1 << BAUD_WIDTH) - 32'h1);

    // lock all but pin disables while enabled; the on bit itself stays writable
    always_comb begin
        ctrl_wmask = spb_pkg::CTRL_MASK;
        if (port_control[spb_pkg::CTRL_ON_BIT]) begin
            ctrl_wmask = '0;
            ctrl_wmask[spb_pkg::CTRL_ON_BIT]      = 1'b1;
            ctrl_wmask[spb_pkg::CTRL_OUT_DIS_BIT] = 1'b1;
            ctrl_wmask[spb_pkg::CTRL_IN_DIS_BIT]  = 1'b1;
        end
    end

    always_comb begin
        next_control = apply(port_control, req.wdata, op_of(req.addr), ctrl_wmask);
        next_extra   = apply(port_control_extra, req.wdata, op_of(req.addr),
                             spb_pkg::CTRL_EXTRA_MASK);
        next_baud    = apply(baud_divisor, req.wdata, op_of(req.addr), baud_impl);
        next_ovf_word = apply(port_status_sw, req.wdata, op_of(req.addr),
                              spb_pkg::STATUS_WR_MASK);
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            port_control <= spb_pkg::CTRL_RESET;
        end else if (req.wr && hit(req.addr, spb_pkg::ADDR_CTRL)) begin
            port_control <= next_control;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            port_control_extra <= spb_pkg::CTRL_EXTRA_RESET;
        end else if (req.wr && hit(req.addr, spb_pkg::ADDR_CTRL_EXTRA)) begin
            port_control_extra <= next_extra;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            baud_divisor <= spb_pkg::BAUD_RESET;
        end else if (req.wr && hit(req.addr, spb_pkg::ADDR_BAUD)) begin
            baud_divisor <= next_baud;
        end
    end

    // overflow flag: engine set wins over a software clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            overflow <= 1'b0;
        end else if (ENGINE_RX_VALID && overflow_pending()) begin
            overflow <= 1'b1;
        end else if (req.wr && hit(req.addr, spb_pkg::ADDR_STATUS)) begin
            overflow <= next_ovf_word[spb_pkg::STATUS_OVF_BIT];
        end
    end
    assign port_status_sw = {25'h0, overflow, 6'h0};

    logic rx_full;
    function automatic logic overflow_pending();
        overflow_pending = rx_full;
    endfunction

    // data buffer: writes load transmit data, engine fills receive side
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            data_buffer <= spb_pkg::DATA_RESET;
            rx_full     <= 1'b0;
        end else if (ENGINE_RX_VALID) begin
            data_buffer <= ENGINE_RX_DATA;
            rx_full     <= 1'b1;
        end else if (req.rd && (req.addr == spb_pkg::ADDR_DATA)) begin
            // buffer has no aliases, so only a read of the base drains it
            rx_full <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            TX_DATA <= spb_pkg::DATA_RESET;
            TX_LOAD <= 1'b0;
        end else begin
            TX_LOAD <= req.wr && (req.addr == spb_pkg::ADDR_DATA);
            if (req.wr && (req.addr == spb_pkg::ADDR_DATA)) begin
                TX_DATA <= req.wdata;
            end
        end
    end

    // status word, only implemented bits shown
    always_comb begin
        status_word = '0;
        status_word[spb_pkg::STATUS_OVF_BIT]  = overflow;
        status_word[spb_pkg::STATUS_BUSY_BIT] = ENGINE_BUSY;
        status_word[0]                        = rx_full;
    end

    // alias reads return zero; software must not rely on them
    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            RDATA <= '0;
        end else if (req.rd) begin
            case (req.addr)
                spb_pkg::ADDR_CTRL:       RDATA <= port_control & spb_pkg::CTRL_MASK;
                spb_pkg::ADDR_CTRL_EXTRA: RDATA <= port_control_extra;
                spb_pkg::ADDR_STATUS:     RDATA <= status_word;
                spb_pkg::ADDR_DATA:       RDATA <= data_buffer;
                spb_pkg::ADDR_BAUD:       RDATA <= baud_divisor & baud_impl;
                default:                  RDATA <= '0;
            endcase
        end else begin
            RDATA <= '0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            WORD_WIDTH <= spb_pkg::SPB_W8;
        end else if (port_control_extra[spb_pkg::EXTRA_AUDIO_BIT]) begin
            WORD_WIDTH <= spb_pkg::SPB_WAUD;
        end else if (port_control[spb_pkg::CTRL_WSEL_HI_BIT]) begin
            WORD_WIDTH <= spb_pkg::SPB_W32;
        end else if (port_control[spb_pkg::CTRL_WSEL_LO_BIT]) begin
            WORD_WIDTH <= spb_pkg::SPB_W16;
        end else begin
            WORD_WIDTH <= spb_pkg::SPB_W8;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!NRST) begin
            PORT_ENABLE            <= 1'b0;
            CONTROLLER_ROLE_SELECT <= 1'b0;
            OUTPUT_PIN_DISABLE     <= 1'b0;
            INPUT_PIN_DISABLE      <= 1'b0;
            BAUD_DIVISOR_FIELD     <= '0;
        end else begin
            PORT_ENABLE            <= port_control[spb_pkg::CTRL_ON_BIT];
            CONTROLLER_ROLE_SELECT <= port_control[spb_pkg::CTRL_ROLE_BIT];
            OUTPUT_PIN_DISABLE     <= port_control[spb_pkg::CTRL_OUT_DIS_BIT];
            INPUT_PIN_DISABLE      <= port_control[spb_pkg::CTRL_IN_DIS_BIT];
            BAUD_DIVISOR_FIELD     <= baud_divisor[12:0];
        end
    end

    // assertions
    a_clear_alias: assert property (@(posedge MCLK) disable iff (!NRST)
        (WR && ADDR == (spb_pkg::ADDR_BAUD | spb_pkg::ALIAS_CLR))
        |=> ((baud_divisor & $past(WDATA)) == 32'h0))
        else $error("clear alias left bits set");
    a_set_alias: assert property (@(posedge MCLK) disable iff (!NRST)
        (WR && ADDR == (spb_pkg::ADDR_BAUD | spb_pkg::ALIAS_SET))
        |=> ((baud_divisor & $past(WDATA) & baud_impl) == ($past(WDATA) & baud_impl)))
        else $error("set alias missed bits");
    a_inv_alias: assert property (@(posedge MCLK) disable iff (!NRST)
        (WR && ADDR == (spb_pkg::ADDR_BAUD | spb_pkg::ALIAS_INV))
        |=> (baud_divisor == ($past(baud_divisor) ^ ($past(WDATA) & baud_impl))))
        else $error("invert alias wrong");
    a_unimpl_zero: assert property (@(posedge MCLK) disable iff (!NRST)
        RD && ADDR == spb_pkg::ADDR_CTRL |=> (RDATA & ~spb_pkg::CTRL_MASK) == 32'h0)
        else $error("unimplemented control bits read nonzero");
    a_baud_width: assert property (@(posedge MCLK) disable iff (!NRST)
        (baud_divisor & ~32'h0000_1fff) == 32'h0)
        else $error("divisor above 13 bits");
    a_enabled_lock: assert property (@(posedge MCLK) disable iff (!NRST)
        port_control[spb_pkg::CTRL_ON_BIT] && $stable(port_control[spb_pkg::CTRL_ON_BIT])
        |=> (port_control[11:5] == $past(port_control[11:5])) || !$past(WR))
        else $error("locked control field changed");
    a_width_decode: assert property (@(posedge MCLK) disable iff (!NRST)
        !port_control_extra[spb_pkg::EXTRA_AUDIO_BIT] && port_control[11]
        && $stable(port_control) && $stable(port_control_extra)
        |=> WORD_WIDTH == spb_pkg::SPB_W32)
        else $error("width select not 32 bit");
    a_ctrl_reset: assert property (@(posedge MCLK)
        !NRST |=> port_control == 32'h0)
        else $error("control not cleared by reset");
    a_clr_ctrl: assert property (@(posedge MCLK) disable iff (!NRST)
        WR && ADDR == (spb_pkg::ADDR_CTRL | spb_pkg::ALIAS_CLR)
        && !port_control[spb_pkg::CTRL_ON_BIT]
        |=> (port_control & $past(WDATA) & spb_pkg::CTRL_MASK) == 32'h0)
        else $error("control clear alias left bits set");
    a_clr_extra: assert property (@(posedge MCLK) disable iff (!NRST)
        WR && ADDR == (spb_pkg::ADDR_CTRL_EXTRA | spb_pkg::ALIAS_CLR)
        |=> (port_control_extra & $past(WDATA)) == 32'h0)
        else $error("extra clear alias left bits set");
    a_set_ctrl: assert property (@(posedge MCLK) disable iff (!NRST)
        WR && ADDR == (spb_pkg::ADDR_CTRL | spb_pkg::ALIAS_SET)
        && !port_control[spb_pkg::CTRL_ON_BIT]
        |=> (port_control & $past(WDATA) & spb_pkg::CTRL_MASK)
            == ($past(WDATA) & spb_pkg::CTRL_MASK))
        else $error("control set alias missed bits");
    a_ctrl_unimpl: assert property (@(posedge MCLK) disable iff (!NRST)
        (port_control & ~spb_pkg::CTRL_MASK) == 32'h0)
        else $error("unimplemented control bit set");
    a_extra_unimpl: assert property (@(posedge MCLK) disable iff (!NRST)
        RD && ADDR == spb_pkg::ADDR_CTRL_EXTRA
        |=> (RDATA & ~spb_pkg::CTRL_EXTRA_MASK) == 32'h0)
        else $error("unimplemented extra bits read nonzero");
    a_baud_field: assert property (@(posedge MCLK) disable iff (!NRST)
        $past(NRST) |-> BAUD_DIVISOR_FIELD == $past(baud_divisor[12:0]))
        else $error("divisor field copy wrong");
    a_lock_fields: assert property (@(posedge MCLK) disable iff (!NRST)
        WR && port_control[spb_pkg::CTRL_ON_BIT]
        && (ADDR & ~spb_pkg::ALIAS_MASK) == spb_pkg::ADDR_CTRL
        |=> ((port_control ^ $past(port_control)) & ~32'h0000_9010) == 32'h0)
        else $error("locked control bit changed while enabled");
    a_width_16: assert property (@(posedge MCLK) disable iff (!NRST)
        !port_control_extra[spb_pkg::EXTRA_AUDIO_BIT]
        && !port_control[spb_pkg::CTRL_WSEL_HI_BIT]
        && port_control[spb_pkg::CTRL_WSEL_LO_BIT]
        |=> WORD_WIDTH == spb_pkg::SPB_W16)
        else $error("width select not 16 bit");
    a_width_8: assert property (@(posedge MCLK) disable iff (!NRST)
        !port_control_extra[spb_pkg::EXTRA_AUDIO_BIT]
        && !port_control[spb_pkg::CTRL_WSEL_HI_BIT]
        && !port_control[spb_pkg::CTRL_WSEL_LO_BIT]
        |=> WORD_WIDTH == spb_pkg::SPB_W8)
        else $error("width select not 8 bit");
    a_outputs_reset: assert property (@(posedge MCLK)
        !NRST |=> !PORT_ENABLE && !CONTROLLER_ROLE_SELECT && !TX_LOAD && RDATA == 32'h0)
        else $error("outputs not cleared by reset");
    a_ovf_set_wins: assert property (@(posedge MCLK) disable iff (!NRST)
        ENGINE_RX_VALID && rx_full |=> overflow)
        else $error("overflow lost to a clear");
    a_rdata_idle: assert property (@(posedge MCLK) disable iff (!NRST)
        !RD |=> RDATA == 32'h0)
        else $error("read data outside the read cycle");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
 * tb_top: self-checking bench for the serial port register bank.
 * assumes spb_pkg and spb_bank are compiled first; the bench stands in for the shift engine.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module tb_top;
    localparam logic [7:0] CTL = spb_pkg::ADDR_CTRL;
    localparam logic [7:0] CLR = spb_pkg::ALIAS_CLR;
    localparam logic [7:0] SET = spb_pkg::ALIAS_SET;
    localparam logic [7:0] INV = spb_pkg::ALIAS_INV;
    logic        mclk;
    logic        nrst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        busy;
    logic        rx_valid;
    logic [31:0] rx_data;
    logic        port_en;
    logic        role;
    logic        out_dis;
    logic        in_dis;
    logic [1:0]  width;
    logic [31:0] tx_data;
    logic        tx_load;
    logic [12:0] baud;
    int          bad_count = 0;
    int          tests_run = 0;

    spb_bank #(.BAUD_WIDTH(13)) i_dut (
        .MCLK(mclk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ENGINE_BUSY(busy), .ENGINE_RX_VALID(rx_valid),
        .ENGINE_RX_DATA(rx_data), .PORT_ENABLE(port_en), .CONTROLLER_ROLE_SELECT(role),
        .OUTPUT_PIN_DISABLE(out_dis), .INPUT_PIN_DISABLE(in_dis), .WORD_WIDTH(width),
        .TX_DATA(tx_data), .TX_LOAD(tx_load), .BAUD_DIVISOR_FIELD(baud)
    );

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // outputs lag the register by one more edge
    task automatic out_chk(input logic [5:0] e);
        @(posedge mclk);
        #1;
        `CHK({port_en, role, out_dis, in_dis, width}, e)
    endtask

    initial begin
        #200000;
        bad_count++;
        summarize();
    end

    initial begin
        nrst = 1'b0; addr = 8'h00; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
        busy = 1'b0; rx_valid = 1'b0; rx_data = 32'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_chk(CTL, 32'h0);
        out_chk(6'h00);
        rd_chk(spb_pkg::ADDR_BAUD, 32'h0);
        // port left off here so the lock does not hide the alias writes
        wr_reg(CTL, 32'h7fff_7fff);
        rd_chk(CTL, 32'h7fff_7fff & spb_pkg::CTRL_MASK);
        out_chk(6'b011110);
        rd_chk(CTL | CLR, 32'h0);
        wr_reg(CTL | CLR, 32'h0000_0800);
        rd_chk(CTL, 32'h7f83_37ff);
        out_chk(6'b011101);
        wr_reg(CTL | CLR, 32'hffff_ffff);
        rd_chk(CTL, 32'h0);
        out_chk(6'b000000);
        wr_reg(CTL | SET, 32'h0000_0c20);
        rd_chk(CTL, 32'h0000_0c20);
        wr_reg(CTL | SET, 32'h0000_0001);
        rd_chk(CTL, 32'h0000_0c21);
        // bit 14 is unimplemented and must not toggle
        wr_reg(CTL | INV, 32'h0000_5010);
        rd_chk(CTL, 32'h0000_1c31);
        wr_reg(CTL | SET, 32'h0000_8000);
        out_chk(6'b111110);
        wr_reg(CTL, 32'h0000_8000);
        rd_chk(CTL, 32'h0000_8c21);
        wr_reg(CTL | INV, 32'h0000_0c10);
        rd_chk(CTL, 32'h0000_8c31);
        wr_reg(CTL | CLR, 32'h0000_8000);
        rd_chk(CTL, 32'h0000_0c31);
        wr_reg(spb_pkg::ADDR_CTRL_EXTRA, 32'hffff_ffff);
        rd_chk(spb_pkg::ADDR_CTRL_EXTRA, spb_pkg::CTRL_EXTRA_MASK);
        out_chk(6'b010111);
        wr_reg(spb_pkg::ADDR_CTRL_EXTRA | CLR, 32'h0000_0080);
        out_chk(6'b010110);
        wr_reg(spb_pkg::ADDR_BAUD, 32'hffff_ffff);
        rd_chk(spb_pkg::ADDR_BAUD, 32'h0000_1fff);
        wr_reg(spb_pkg::ADDR_BAUD | INV, 32'h0000_0001);
        rd_chk(spb_pkg::ADDR_BAUD, 32'h0000_1ffe);
        `CHK(baud, 13'h1ffe)
        wr_reg(spb_pkg::ADDR_DATA, 32'ha5a5_5a5a);
        #1;
        `CHK(tx_load, 1'b1)
        @(posedge mclk);
        #1;
        `CHK({tx_load, tx_data}, {1'b0, 32'ha5a5_5a5a})
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_data  <= 32'h1234_5678;
        busy     <= 1'b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0801);
        // buffer aliases act as unmapped and leave it full
        rd_chk(spb_pkg::ADDR_DATA | CLR, 32'h0);
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0801);
        rd_chk(spb_pkg::ADDR_DATA, 32'h1234_5678);
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0800);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_data  <= 32'hcafe_0001;
        @(posedge mclk);
        rx_valid <= 1'b0;
        // a word while full raises overflow; a clear in the same cycle loses
        @(posedge mclk);
        addr     <= spb_pkg::ADDR_STATUS | CLR;
        wdata    <= 32'h0000_0040;
        wr       <= 1'b1;
        rx_valid <= 1'b1;
        rx_data  <= 32'hcafe_0002;
        @(posedge mclk);
        wr       <= 1'b0;
        rx_valid <= 1'b0;
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0841);
        rd_chk(spb_pkg::ADDR_DATA, 32'hcafe_0002);
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0840);
        wr_reg(spb_pkg::ADDR_STATUS | CLR, 32'h0000_0040);
        rd_chk(spb_pkg::ADDR_STATUS, 32'h0000_0800);
        // unmapped places read zero
        rd_chk(8'h50, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
